// ---- design/saec_map.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef SAEC_MAP_SVH
`define SAEC_MAP_SVH

// ============================================================
// Register offsets (byte addresses)
`define SAEC_ADDR_CTRL2         8'h00
`define SAEC_ADDR_CTRL1         8'h04
`define SAEC_ADDR_STATUS        8'h08
`define SAEC_ADDR_TXDATA        8'h0C
`define SAEC_ADDR_RXDATA        8'h10

// ============================================================
// Control register 2 field positions
`define SAEC_BIT_SIGN_EXT       15
`define SAEC_BIT_FRAME_ERROR_FLAG_EN      12
`define SAEC_BIT_ROV_EN         11
`define SAEC_BIT_TUR_EN         10
`define SAEC_BIT_IGN_ROV        9
`define SAEC_BIT_IGN_TUR        8
`define SAEC_BIT_AUD_EN         7
`define SAEC_BIT_MONO           3
`define SAEC_FLD_MODE_HI        1
`define SAEC_FLD_MODE_LO        0
`define SAEC_CTRL2_WMASK        32'h0000_9F8B

// ============================================================
// Control register 1 and status fields
`define SAEC_BIT_ON             0
`define SAEC_BIT_HALT           3
`define SAEC_BIT_FRAME_ERROR_FLAG         2
`define SAEC_BIT_ROV            1
`define SAEC_BIT_TUR            0

// ============================================================
// Reset values
`define SAEC_RST_CTRL2          32'h0000_0000
`define SAEC_RST_CTRL1          32'h0000_0000

// ============================================================
// Timing: link clock period in bench, for reference
`define SAEC_LINK_PERIOD_NS     32
`define SAEC_SYS_PERIOD_NS      4

`endif

// ---- design/saec_pkg.sv ----
// Types shared by the serial audio error control block
package saec_pkg;

    typedef enum logic [1:0]
    {
        SAEC_FRAME_I2S,
        SAEC_FRAME_LEFT,
        SAEC_FRAME_RIGHT,
        SAEC_FRAME_PCM
    } saec_framing_e;

    typedef enum logic [1:0]
    {
        SAEC_ST_IDLE,
        SAEC_ST_RUN,
        SAEC_ST_HALT
    } saec_state_e;

endpackage

// ---- design/saec_sync.sv ----
// Two-flop synchroniser for signals from outside the clock domain
`timescale 1ns/1ps

module saec_sync
#(
    parameter int WIDTH = 1
)
(
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst_b,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta;

    initial
    begin
        if (WIDTH < 1)
        begin
            $error("saec_sync: WIDTH must be at least 1");
        end
    end

    // ============================================================
    // First stage is read only by the second stage
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            meta   <= '0;
            o_sync <= '0;
        end
        else
        begin
            meta   <= i_async;
            o_sync <= meta;
        end
    end

endmodule

// ---- design/saec_top.sv ----
// Serial audio error control: control register 2 and its effects on the serial unit
// ============================================================
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps

`include "saec_map.svh"

module saec_top
#(
    parameter int DATA_W = 16
)
(
    input  wire logic              i_clk_sys,
    input  wire logic              i_rst_b,
    input  wire logic [7:0]        i_addr,
    input  wire logic [31:0]       i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [31:0]       o_rdata,
    input  wire logic              i_link_clk,
    input  wire logic              i_link_frame,
    input  wire logic              i_link_sdi,
    output logic                   o_link_sdo,
    output logic                   o_link_slot_right,
    output logic [1:0]             o_framing,
    output logic                   o_audio_active,
    output logic                   o_error_event
);

    // ============================================================
    // Register state
    logic                  rx_sign_extend;
    logic                  frame_error_event_enable;
    logic                  rx_overflow_event_enable;
    logic                  tx_underrun_event_enable;
    logic                  ignore_rx_overflow;
    logic                  ignore_tx_underrun;
    logic                  audio_protocol_enable;
    logic                  audio_mono_select;
    logic [1:0]            audio_framing_select;
    logic                  module_on;
    logic                  frame_error_flag;
    logic                  rx_overflow_flag;
    logic                  tx_underrun_flag;
    logic                  halted;
    logic [DATA_W-1:0]     transmit_buffer;
    logic                  tx_full;
    logic [DATA_W-1:0]     rx_hold;
    logic                  rx_full;
    logic [DATA_W-1:0]     tx_shift;
    logic [DATA_W-1:0]     rx_shift;
    logic [$clog2(DATA_W+1)-1:0] bit_cnt;
    logic                  slot_right;
    logic                  mono_repeat;
    logic [DATA_W-1:0]     mono_word;
    logic [31:0]           next_rdata;
    logic [31:0]           rx_word;
    saec_pkg::saec_state_e state;
    logic                  clk_s;
    logic                  frame_s;
    logic                  sdi_s;
    logic                  clk_d;
    logic                  frame_d;
    logic                  sck_rise;
    logic                  sck_fall;
    logic                  frame_edge;
    logic                  word_done;
    logic                  frame_err_evt;
    logic                  rov_evt;
    logic                  tur_evt;
    logic                  eff_mono;
    logic                  sw_rx_pop;
    logic                  sw_tx_push;
    logic                  frame_arm;
    localparam int         CNT_W = $clog2(DATA_W+1);

    initial
    begin
        if (DATA_W < 2 || DATA_W > 32)
        begin
            $error("saec_top: DATA_W must be 2 to 32");
        end
    end

    // ============================================================
    // Pin synchronisers
    saec_sync #(.WIDTH(3)) u_sync
    (
        .i_clk_sys (i_clk_sys),
        .i_rst_b   (i_rst_b),
        .i_async   ({i_link_clk, i_link_frame, i_link_sdi}),
        .o_sync    ({clk_s, frame_s, sdi_s})
    );

    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            clk_d     <= 1'b0;
            frame_d   <= 1'b0;
            frame_arm <= 1'b0;
        end
        else
        begin
            clk_d   <= clk_s;
            frame_d <= frame_s;
            // Frame level moves well before the bit clock edge that opens the slot
            if (sck_rise)
            begin
                frame_arm <= 1'b0;
            end
            else if (frame_s ^ frame_d)
            begin
                frame_arm <= 1'b1;
            end
        end
    end

    assign sck_rise   = clk_s & ~clk_d;
    assign sck_fall   = ~clk_s & clk_d;
    // Audio framing keys on any edge of the word select; plain mode on frame start
    assign frame_edge = sck_rise & (frame_arm | (frame_s ^ frame_d))
                        & (audio_protocol_enable | frame_s);
    assign word_done  = sck_rise && (bit_cnt == CNT_W'(DATA_W - 1));

    // ============================================================
    // Mode decode
    assign eff_mono          = audio_protocol_enable & audio_mono_select;
    assign o_framing         = audio_protocol_enable ? audio_framing_select : 2'h0;
    assign o_audio_active    = audio_protocol_enable & module_on;
    assign o_link_slot_right = slot_right;
    assign sw_rx_pop  = i_rd && (i_addr == `SAEC_ADDR_RXDATA);
    assign sw_tx_push = i_wr && (i_addr == `SAEC_ADDR_TXDATA);

    // ============================================================
    // Control register 2
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rx_sign_extend           <= 1'b0;
            frame_error_event_enable <= 1'b0;
            rx_overflow_event_enable <= 1'b0;
            tx_underrun_event_enable <= 1'b0;
            ignore_rx_overflow       <= 1'b0;
            ignore_tx_underrun       <= 1'b0;
            audio_protocol_enable    <= 1'b0;
            audio_mono_select        <= 1'b0;
            audio_framing_select     <= 2'h0;
        end
        else if (i_wr && i_addr == `SAEC_ADDR_CTRL2)
        begin
            rx_sign_extend           <= i_wdata[`SAEC_BIT_SIGN_EXT];
            frame_error_event_enable <= i_wdata[`SAEC_BIT_FRAME_ERROR_FLAG_EN];
            rx_overflow_event_enable <= i_wdata[`SAEC_BIT_ROV_EN];
            tx_underrun_event_enable <= i_wdata[`SAEC_BIT_TUR_EN];
            ignore_rx_overflow       <= i_wdata[`SAEC_BIT_IGN_ROV];
            ignore_tx_underrun       <= i_wdata[`SAEC_BIT_IGN_TUR];
            // Writes to audio fields are dropped while the module runs
            if (!module_on)
            begin
                audio_protocol_enable <= i_wdata[`SAEC_BIT_AUD_EN];
                audio_mono_select     <= i_wdata[`SAEC_BIT_MONO];
                audio_framing_select  <= i_wdata[`SAEC_FLD_MODE_HI:`SAEC_FLD_MODE_LO];
            end
        end
    end

    // ============================================================
    // Control register 1: module enable
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            module_on <= 1'b0;
        end
        else if (i_wr && i_addr == `SAEC_ADDR_CTRL1)
        begin
            module_on <= i_wdata[`SAEC_BIT_ON];
        end
    end

    // ============================================================
    // Serial state: halt on critical errors, restart by re-enabling
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state <= saec_pkg::SAEC_ST_IDLE;
        end
        else
        begin
            case (state)
                saec_pkg::SAEC_ST_IDLE:
                begin
                    if (module_on)
                    begin
                        state <= saec_pkg::SAEC_ST_RUN;
                    end
                end
                saec_pkg::SAEC_ST_RUN:
                begin
                    if (!module_on)
                    begin
                        state <= saec_pkg::SAEC_ST_IDLE;
                    end
                    else if ((rov_evt && !ignore_rx_overflow) ||
                             (tur_evt && !ignore_tx_underrun))
                    begin
                        state <= saec_pkg::SAEC_ST_HALT;
                    end
                end
                saec_pkg::SAEC_ST_HALT:
                begin
                    if (!module_on)
                    begin
                        state <= saec_pkg::SAEC_ST_IDLE;
                    end
                end
                default:
                begin
                    state <= saec_pkg::SAEC_ST_IDLE;
                end
            endcase
        end
    end

    assign halted = (state == saec_pkg::SAEC_ST_HALT);

    // ============================================================
    // Error detection
    assign frame_err_evt = (state == saec_pkg::SAEC_ST_RUN) && frame_edge
                           && (bit_cnt != '0);
    assign rov_evt = (state == saec_pkg::SAEC_ST_RUN) && word_done && rx_full && !sw_rx_pop;
    assign tur_evt = (state == saec_pkg::SAEC_ST_RUN) && sck_rise && frame_edge
                     && !tx_full && !mono_repeat;

    // ============================================================
    // Sticky flags; a set in the clearing cycle wins
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            frame_error_flag <= 1'b0;
            rx_overflow_flag <= 1'b0;
            tx_underrun_flag <= 1'b0;
        end
        else
        begin
            if (i_wr && i_addr == `SAEC_ADDR_STATUS)
            begin
                frame_error_flag <= frame_error_flag & ~i_wdata[`SAEC_BIT_FRAME_ERROR_FLAG];
                rx_overflow_flag <= rx_overflow_flag & ~i_wdata[`SAEC_BIT_ROV];
                tx_underrun_flag <= tx_underrun_flag & ~i_wdata[`SAEC_BIT_TUR];
            end
            if (frame_err_evt)
            begin
                frame_error_flag <= 1'b1;
            end
            if (rov_evt)
            begin
                rx_overflow_flag <= 1'b1;
            end
            if (tur_evt)
            begin
                tx_underrun_flag <= 1'b1;
            end
        end
    end

    // ============================================================
    // Error event output, enabled events OR-ed into one registered pulse per cycle
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_error_event <= 1'b0;
        end
        else
        begin
            o_error_event <= (frame_err_evt & frame_error_event_enable)
                           | (rov_evt & rx_overflow_event_enable)
                           | (tur_evt & tx_underrun_event_enable);
        end
    end

    // ============================================================
    // Transmit buffer and shifter
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            transmit_buffer <= '0;
            tx_full         <= 1'b0;
            tx_shift        <= '0;
            mono_word       <= '0;
            mono_repeat     <= 1'b0;
            slot_right      <= 1'b0;
            bit_cnt         <= '0;
            o_link_sdo      <= 1'b0;
        end
        else
        begin
            if (sw_tx_push && !tx_full)
            begin
                transmit_buffer <= i_wdata[DATA_W-1:0];
                tx_full         <= 1'b1;
            end
            if (state != saec_pkg::SAEC_ST_RUN)
            begin
                bit_cnt     <= '0;
                mono_repeat <= 1'b0;
                o_link_sdo  <= 1'b0;
            end
            else if (frame_edge)
            begin
                // The slot edge itself carries the first bit
                bit_cnt    <= CNT_W'(1);
                slot_right <= audio_protocol_enable ? frame_s : 1'b0;
                if (mono_repeat)
                begin
                    // Second slot repeats the word sent in the slot before
                    tx_shift    <= mono_word;
                    mono_repeat <= 1'b0;
                end
                else if (tx_full)
                begin
                    tx_shift    <= transmit_buffer;
                    mono_word   <= transmit_buffer;
                    mono_repeat <= eff_mono;
                    tx_full     <= sw_tx_push;
                    if (sw_tx_push)
                    begin
                        transmit_buffer <= i_wdata[DATA_W-1:0];
                    end
                end
                else
                begin
                    // Underrun with ignore set sends zeros until data arrives
                    tx_shift <= '0;
                end
            end
            else
            begin
                if (sck_rise)
                begin
                    // Wrap at word end so the next slot edge is no frame error
                    bit_cnt <= word_done ? '0 : bit_cnt + 1'b1;
                end
                if (sck_fall)
                begin
                    o_link_sdo <= tx_shift[DATA_W-1];
                    tx_shift   <= {tx_shift[DATA_W-2:0], 1'b0};
                end
            end
        end
    end

    // ============================================================
    // Receive shifter and hold word
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rx_shift <= '0;
            rx_hold  <= '0;
            rx_full  <= 1'b0;
        end
        else
        begin
            if (sw_rx_pop)
            begin
                rx_full <= 1'b0;
            end
            if (state == saec_pkg::SAEC_ST_RUN && sck_rise)
            begin
                rx_shift <= {rx_shift[DATA_W-2:0], sdi_s};
                if (word_done && (!rx_full || sw_rx_pop))
                begin
                    rx_hold <= {rx_shift[DATA_W-2:0], sdi_s};
                    rx_full <= 1'b1;
                end
                // On overflow the held word is kept, never overwritten
            end
        end
    end

    // ============================================================
    // Read data
    always_comb
    begin
        rx_word = '0;
        rx_word[DATA_W-1:0] = rx_hold;
        if (rx_sign_extend)
        begin
            rx_word[31:DATA_W-1] = {(33-DATA_W){rx_hold[DATA_W-1]}};
        end
        next_rdata = 32'h0000_0000;
        case (i_addr)
            `SAEC_ADDR_CTRL2:
            begin
                next_rdata[`SAEC_BIT_SIGN_EXT]  = rx_sign_extend;
                next_rdata[`SAEC_BIT_FRAME_ERROR_FLAG_EN] = frame_error_event_enable;
                next_rdata[`SAEC_BIT_ROV_EN]    = rx_overflow_event_enable;
                next_rdata[`SAEC_BIT_TUR_EN]    = tx_underrun_event_enable;
                next_rdata[`SAEC_BIT_IGN_ROV]   = ignore_rx_overflow;
                next_rdata[`SAEC_BIT_IGN_TUR]   = ignore_tx_underrun;
                next_rdata[`SAEC_BIT_AUD_EN]    = audio_protocol_enable;
                next_rdata[`SAEC_BIT_MONO]      = audio_mono_select;
                next_rdata[`SAEC_FLD_MODE_HI:`SAEC_FLD_MODE_LO] = audio_framing_select;
            end
            `SAEC_ADDR_CTRL1:
            begin
                next_rdata[`SAEC_BIT_ON] = module_on;
            end
            `SAEC_ADDR_STATUS:
            begin
                next_rdata[`SAEC_BIT_HALT]   = halted;
                next_rdata[`SAEC_BIT_FRAME_ERROR_FLAG] = frame_error_flag;
                next_rdata[`SAEC_BIT_ROV]    = rx_overflow_flag;
                next_rdata[`SAEC_BIT_TUR]    = tx_underrun_flag;
            end
            `SAEC_ADDR_RXDATA:
            begin
                next_rdata = rx_word;
            end
            default:
            begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_rdata <= 32'h0000_0000;
        end
        else
        begin
            o_rdata <= i_rd ? next_rdata : 32'h0000_0000;
        end
    end

endmodule

// ---- testbench/saec_link_model.sv ----
// Serial partner: makes bit clock and frame, sends and catches words
`timescale 1ns/1ps

// ====================
// Link partner
module saec_link_model
(
    output logic      o_clk,
    output logic      o_frame,
    output logic      o_sdi,
    input  wire logic i_sdo
);
    logic [15:0] got;

    initial
    begin
        o_clk = 1'b0;
        o_frame = 1'b0;
        o_sdi = 1'b1;
        got = 16'h0;
    end

    // Clock idles low between words; odd offsets keep edges off the system edge
    task automatic xfer(input logic [15:0] w, input logic lvl, input logic drop, input int n);
        #1;
        o_frame = lvl;
        o_sdi = w[15];
        for (int i = 0; i < n; i++)
        begin
            #16 o_clk = 1'b1;
            #14 if (i > 0) got = {got[14:0], i_sdo};
            #2 o_clk = 1'b0;
            o_sdi = (i < n - 1) ? w[14-i] : ~o_sdi;
        end
        #30 got = {got[14:0], i_sdo};
        if (drop)
            o_frame = 1'b0;
        #64;
    endtask
endmodule

// ---- testbench/saec_sva.sv ----
// Port checker for the serial audio error control block
`timescale 1ns/1ps

// ====================
// Checker
module saec_sva
#(
    parameter int DATA_W = 16
)
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_b,
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [31:0] o_rdata,
    input  wire logic [1:0]  o_framing,
    input  wire logic        o_audio_active,
    input  wire logic        o_error_event
);
    logic        on_q;
    logic [31:0] c2_q;
    logic [3:0]  quiet;

    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
            on_q <= 1'b0;
        else if (i_wr && i_addr == 8'h04)
            on_q <= i_wdata[0];
    end

    // Audio fields hold their value while the module is on
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
            c2_q <= 32'h0;
        else if (i_wr && i_addr == 8'h00)
            c2_q <= on_q ? ((c2_q & 32'h8B) | (i_wdata & 32'h9F00)) : (i_wdata & 32'h9F8B);
    end

    // Events still in flight may land shortly after the enables drop
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
            quiet <= 4'h0;
        else if (c2_q[12:10] != 3'h0)
            quiet <= 4'h0;
        else if (quiet != 4'h8)
            quiet <= quiet + 4'h1;
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);

    sequence s_c2_wr_on;
        on_q && i_wr && i_addr == 8'h00;
    endsequence

    sequence s_rx_rd;
        i_rd && i_addr == 8'h10;
    endsequence

    a_ctrl2_read: assert property (
        $past(i_rd && i_addr == 8'h00) |-> o_rdata == $past(c2_q))
        else $error("control read mismatch");
    a_mode_locked: assert property (
        s_c2_wr_on |=> $stable(o_framing) && $stable(o_audio_active))
        else $error("audio fields changed while on");
    a_framing_gate: assert property (
        !c2_q[7] |-> o_framing == 2'h0)
        else $error("framing shown without audio");
    a_active_map: assert property (
        o_audio_active == (on_q && c2_q[7]))
        else $error("audio active mismatch");
    a_framing_map: assert property (
        o_audio_active |-> o_framing == c2_q[1:0])
        else $error("framing mismatch");
    a_event_pulse: assert property (
        o_error_event |=> !o_error_event)
        else $error("error event too long");
    a_event_masked: assert property (
        quiet == 4'h8 |-> !o_error_event)
        else $error("error event while disabled");
    a_rx_extend: assert property (
        s_rx_rd |=> o_rdata[31:DATA_W] ==
            ($past(c2_q[15]) ? {(32-DATA_W){o_rdata[DATA_W-1]}} : '0))
        else $error("receive word upper bits wrong");
endmodule

bind saec_top saec_sva #(.DATA_W(DATA_W)) u_sva
(
    .i_clk_sys      (i_clk_sys),
    .i_rst_b        (i_rst_b),
    .i_addr         (i_addr),
    .i_wdata        (i_wdata),
    .i_wr           (i_wr),
    .i_rd           (i_rd),
    .o_rdata        (o_rdata),
    .o_framing      (o_framing),
    .o_audio_active (o_audio_active),
    .o_error_event  (o_error_event)
);

// ---- testbench/saec_top_tb.sv ----
// Self-checking bench for the serial audio error control block
`timescale 1ns/1ps

// ====================
// Bench top
module saec_top_tb;
    logic        clk;
    logic        rst_b;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        lclk;
    logic        lframe;
    logic        lsdi;
    logic        sdo;
    logic        slot;
    logic [1:0]  framing;
    logic        active;
    logic        ev;
    int          failures;
    int          checks_done;
    int          ev_n;
    int          exp_ev;
    logic [31:0] d;
    logic [15:0] w;
    logic [15:0] t;
    logic [31:0] tab[6] = '{32'h500, 32'h100, 32'h400, 32'hB00, 32'h300, 32'h900};

    saec_top #(.DATA_W(16)) u_dut
    (
        .i_clk_sys         (clk),
        .i_rst_b           (rst_b),
        .i_addr            (addr),
        .i_wdata           (wdata),
        .i_wr              (wr),
        .i_rd              (rd),
        .o_rdata           (rdata),
        .i_link_clk        (lclk),
        .i_link_frame      (lframe),
        .i_link_sdi        (lsdi),
        .o_link_sdo        (sdo),
        .o_link_slot_right (slot),
        .o_framing         (framing),
        .o_audio_active    (active),
        .o_error_event     (ev)
    );

    saec_link_model u_link
    (
        .o_clk   (lclk),
        .o_frame (lframe),
        .o_sdi   (lsdi),
        .i_sdo   (sdo)
    );

    always #2 clk = ~clk;
    always @(posedge clk) if (ev === 1'b1) ev_n++;

    function automatic logic [31:0] ext(input logic [15:0] v, input logic se);
        return se ? {{16{v[15]}}, v} : {16'h0, v};
    endfunction

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        v = rdata;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    // Module is switched off around every change, then the receive word is popped
    task automatic cfg(input logic [31:0] c);
        wr_reg(8'h04, 32'h0);
        wr_reg(8'h00, c);
        wr_reg(8'h04, 32'h1);
        rd_reg(8'h10, d);
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        #100000;
        failures++;
        final_report;
    end

    initial
    begin
        clk = 1'b0;
        rst_b = 1'b0;
        addr = 8'h0;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        void'($urandom(32'h6B5F19D2));
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        rd_reg(8'h00, d);
        chk("ctrl2 reset", 32'h0, d);
        wr_reg(8'h00, 32'hFFFF_FFFF);
        rd_reg(8'h00, d);
        chk("ctrl2 mask", 32'h9F8B, d);
        rd_reg(8'hFC, d);
        chk("unmapped", 32'h0, d);
        chk("framing early", 32'h3, {30'h0, framing});
        wr_reg(8'h04, 32'h1);
        wr_reg(8'h00, 32'h0);
        rd_reg(8'h00, d);
        chk("ctrl2 locked", 32'h8B, d);
        $display("test registers done");
        for (int m = 0; m < 8; m++)
        begin
            cfg((m[2] ? 32'h80 : 32'h0) | (m & 3));
            chk("framing", m[2] ? (m & 3) : 0, {30'h0, framing});
            chk("active", m[2], {31'h0, active});
        end
        $display("test modes done");
        for (int se = 0; se < 2; se++)
        begin
            cfg(32'h300 | (se << 15));
            w = 16'h8000 | 16'($urandom);
            t = 16'($urandom);
            wr_reg(8'h0C, {16'h0, t});
            u_link.xfer(w, 1'b1, 1'b1, 16);
            chk("sdo word", {16'h0, t}, {16'h0, u_link.got});
            rd_reg(8'h10, d);
            chk("rx word", ext(w, se[0]), d);
        end
        $display("test data done");
        for (int k = 0; k < 6; k++)
        begin
            cfg(tab[k]);
            exp_ev += (k % 3 != 1);
            w = 16'($urandom);
            u_link.xfer(w, 1'b1, 1'b1, 16);
            if (k > 2) u_link.xfer(16'($urandom), 1'b1, 1'b1, 16);
            chk("events", exp_ev, ev_n);
            if (k < 2) chk("zeros", 32'h0, {16'h0, u_link.got});
            rd_reg(8'h08, d);
            chk("halted", k % 3 == 2, {31'h0, d[3]});
            rd_reg(8'h10, d);
            if (k > 2) chk("rx kept", ext(w, 1'b0), d);
        end
        $display("test faults done");
        for (int k = 0; k < 2; k++)
        begin
            cfg(k ? 32'h300 : 32'h1300);
            exp_ev += (k == 0);
            u_link.xfer(16'($urandom), 1'b1, 1'b1, 8);
            u_link.xfer(16'($urandom), 1'b1, 1'b1, 16);
            chk("events", exp_ev, ev_n);
        end
        $display("test frame done");
        cfg(32'h389);
        t = 16'($urandom);
        wr_reg(8'h0C, {16'h0, t});
        u_link.xfer(16'($urandom), 1'b1, 1'b0, 16);
        chk("mono right", {16'h0, t}, {16'h0, u_link.got});
        chk("slot right", 32'h1, {31'h0, slot});
        u_link.xfer(16'($urandom), 1'b0, 1'b0, 16);
        chk("mono left", {16'h0, t}, {16'h0, u_link.got});
        chk("slot left", 32'h0, {31'h0, slot});
        $display("test mono done");
        final_report;
    end
endmodule
